// ---- rtl/cgss_sequencer.sv ----
// channel-gain scan sequencer: queue, pacer, burst clock, result buffer
// assumes converter handshake on clk; external pacer is asynchronous
//
// Notes on behaviour
// - 256-entry sixteen-bit channel-gain queue, software loaded
// - entries in any order, repeats, own gains
// - twelve address lines from current entry
// - six assembly lines, six channel lines
// - three gain lines driven with address
// - polarity bit: straight binary or two's complement
// - paced: one conversion per pacer tick
// - burst: pacer pulse scans whole queue
// - burst clock ignored in paced mode
// - pacer source internal or external
// - internal pacer: two counters, 5 MHz base
// - external pacer acts on selected edge
// - burst clock 100 kHz down to 15.625 kHz
`timescale 1ns/1ps
`default_nettype none
module cgss_sequencer
  import cgss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              q_wr_en,
  input  wire logic [IDX_W-1:0]  q_wr_index,
  input  wire cgss_entry_t       q_wr_data,
  input  wire logic [IDX_W-1:0]  queue_last,
  input  wire logic              acq_enable,
  input  wire logic              burst_mode,
  input  wire logic              bipolar,
  input  wire logic              ext_pacer_sel,
  input  wire logic              ext_pacer_rise,
  input  wire logic [DIV_W-1:0]  pacer_div1,
  input  wire logic [DIV_W-1:0]  pacer_div2,
  input  wire logic [6:0]        burst_period_us,
  input  wire logic              ext_pacer_pin,
  output logic [ADDR_W-1:0]      mux_addr,
  output logic [GAIN_W-1:0]      gain_sel,
  output logic                   conv_start,
  input  wire logic              conv_done,
  input  wire logic [DATA_W-1:0] adc_raw,
  output logic                   res_valid,
  input  wire logic              res_ready,
  output var cgss_result_t       res_data,
  output logic                   busy,
  output logic [IDX_W-1:0]       cur_index
);

  // ****************************************
  // channel-gain queue
  // ****************************************
  cgss_entry_t channel_gain_queue_ram [Q_DEPTH];

  always_ff @(posedge clk) begin
    if (q_wr_en) begin
      channel_gain_queue_ram[q_wr_index] <= q_wr_data;
    end
  end

  // ****************************************
  // external pacer synchroniser and edge
  // ****************************************
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_s1_d, ext_s2_d, ext_s3_d;
  logic ext_edge;

  always_comb begin
    ext_s1_d = ext_pacer_pin;
    ext_s2_d = ext_s1_q;
    ext_s3_d = ext_s2_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_s1_d;
      ext_s2_q <= ext_s2_d;
      ext_s3_q <= ext_s3_d;
    end
  end

  // only the chosen edge counts; 10 us spacing left to the source
  assign ext_edge = ext_pacer_rise ? (ext_s2_q && !ext_s3_q)
                                   : (!ext_s2_q && ext_s3_q);

  // ****************************************
  // internal pacer on a 5 MHz time base
  // ****************************************
  logic [TB_W-1:0]  tb_q, tb_d;
  logic [DIV_W-1:0] c1_q, c1_d, c2_q, c2_d;
  logic [DIV_W-1:0] div1_eff, div2_eff;
  logic             tb_tick, c1_wrap, int_tick, pacer_run;

  // clamping divider one keeps the rate at or below 100 kHz
  assign div1_eff = (pacer_div1 < DIV_W'(PACER_MIN)) ?
                    DIV_W'(PACER_MIN) : pacer_div1;
  assign div2_eff = (pacer_div2 == '0) ? DIV_W'(1) : pacer_div2;
  assign pacer_run = acq_enable && !ext_pacer_sel;
  assign tb_tick   = (tb_q == TB_W'(TB_DIV - 1));
  assign c1_wrap   = tb_tick && (c1_q == div1_eff - 1'b1);
  assign int_tick  = c1_wrap && (c2_q == div2_eff - 1'b1);

  always_comb begin
    tb_d = tb_tick ? '0 : tb_q + 1'b1;
    c1_d = c1_q;
    c2_d = c2_q;
    if (!pacer_run) begin
      c1_d = '0;
      c2_d = '0;
    end else if (tb_tick) begin
      c1_d = c1_wrap ? '0 : c1_q + 1'b1;
      if (c1_wrap) begin
        c2_d = int_tick ? '0 : c2_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tb_q <= '0;
      c1_q <= '0;
      c2_q <= '0;
    end else begin
      tb_q <= tb_d;
      c1_q <= c1_d;
      c2_q <= c2_d;
    end
  end

  logic pacer_tick;
  assign pacer_tick = ext_pacer_sel ? ext_edge : int_tick;

  // ****************************************
  // burst conversion clock
  // ****************************************
  logic [BCNT_W-1:0] bc_q, bc_d, burst_cyc;
  logic [6:0]        bper;
  logic              burst_ok;

  always_comb begin
    bper = burst_period_us;
    if (bper < 7'(BURST_MIN_US)) begin
      bper = 7'(BURST_MIN_US);
    end else if (bper > 7'(BURST_MAX_US)) begin
      bper = 7'(BURST_MAX_US);
    end
  end

  assign burst_cyc = BCNT_W'(bper * CYC_PER_US);
  // decided one cycle early: the start pulse itself is registered
  assign burst_ok  = (bc_q >= burst_cyc - 2'd2);

  // restarted at every start, so spacing is start to start
  always_comb begin
    if (conv_start) begin
      bc_d = '0;
    end else if (!burst_ok) begin
      bc_d = bc_q + 1'b1;
    end else begin
      bc_d = bc_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bc_q <= '0;
    end else begin
      bc_q <= bc_d;
    end
  end

  // ****************************************
  // scan state machine
  // ****************************************
  cgss_state_t       st_q, st_d;
  logic [IDX_W-1:0]  idx_q, idx_d;
  logic              pend_q, pend_d, scan_q, scan_d;
  logic              start_q, start_d, push_q, push_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [GAIN_W-1:0] gain_q, gain_d;
  cgss_result_t      res_q, res_d;
  cgss_entry_t       ent;
  logic              fifo_ready, go, consume;

  assign ent = channel_gain_queue_ram[idx_q];

  // burst clock only consulted inside a burst scan
  always_comb begin
    if (burst_mode && scan_q) begin
      go = burst_ok;
    end else begin
      go = pend_q;
    end
  end

  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    scan_d  = scan_q;
    addr_d  = addr_q;
    gain_d  = gain_q;
    res_d   = res_q;
    start_d = 1'b0;
    push_d  = 1'b0;
    consume = 1'b0;
    unique case (st_q)
      CGSS_IDLE: begin
        idx_d  = '0;
        scan_d = 1'b0;
        if (acq_enable) begin
          st_d = CGSS_LOAD;
        end
      end
      CGSS_LOAD: begin
        addr_d = {ent.assembly, ent.channel};
        gain_d = ent.gain;
        st_d   = CGSS_WAIT;
      end
      CGSS_WAIT: begin
        // a full buffer holds the next start back
        if (go && fifo_ready) begin
          start_d = 1'b1;
          st_d    = CGSS_CONV;
          if (!(burst_mode && scan_q)) begin
            consume = 1'b1;
            scan_d  = burst_mode;
          end
        end
      end
      CGSS_CONV: begin
        if (conv_done) begin
          push_d        = 1'b1;
          res_d.entry   = idx_q;
          res_d.sample  = bipolar ? (adc_raw ^ SIGN_FLIP) : adc_raw;
          st_d          = CGSS_LOAD;
          if (idx_q == queue_last) begin
            idx_d  = '0;
            scan_d = 1'b0;
          end else begin
            idx_d = idx_q + 1'b1;
          end
        end
      end
    endcase
    if (!acq_enable) begin
      // abort: no late start pulse or result push on the way out
      st_d    = CGSS_IDLE;
      start_d = 1'b0;
      push_d  = 1'b0;
    end
  end

  // a tick landing on its own consume cycle is kept
  assign pend_d = acq_enable && (pacer_tick || (pend_q && !consume));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q    <= CGSS_IDLE;
      idx_q   <= '0;
      pend_q  <= 1'b0;
      scan_q  <= 1'b0;
      start_q <= 1'b0;
      push_q  <= 1'b0;
      addr_q  <= '0;
      gain_q  <= '0;
      res_q   <= '0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      pend_q  <= pend_d;
      scan_q  <= scan_d;
      start_q <= start_d;
      push_q  <= push_d;
      addr_q  <= addr_d;
      gain_q  <= gain_d;
      res_q   <= res_d;
    end
  end

  assign mux_addr   = addr_q;
  assign gain_sel   = gain_q;
  assign conv_start = start_q;
  assign busy       = (st_q == CGSS_CONV);
  assign cur_index  = idx_q;

  // ****************************************
  // result buffer
  // ****************************************
  // one conversion in flight and the start waits for room,
  // so the push below always finds a free slot
  cgss_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (res_q),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

endmodule // cgss_sequencer
`default_nettype wire

// ---- rtl/cgss_pkg.sv ----
// constants and types of the channel-gain scan sequencer
// assumes a single 50 MHz clock for the whole block
package cgss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int TB_HZ        = 5_000_000;
  localparam int TB_DIV       = CLK_HZ / TB_HZ;
  localparam int MAX_RATE_HZ  = 100_000;
  localparam int PACER_MIN    = TB_HZ / MAX_RATE_HZ;
  localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int BURST_MIN_US = 10;
  localparam int BURST_MAX_US = 64;

  // ****************************************
  // widths and fields
  // ****************************************
  localparam int Q_DEPTH    = 256;
  localparam int IDX_W      = 8;
  localparam int ADDR_W     = 12;
  localparam int HALF_W     = 6;
  localparam int GAIN_W     = 3;
  localparam int DATA_W     = 16;
  localparam int DIV_W      = 16;
  localparam int BCNT_W     = 12;
  localparam int TB_W       = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;

  typedef enum logic [GAIN_W-1:0] {
    CGSS_GAIN_1, CGSS_GAIN_2, CGSS_GAIN_4, CGSS_GAIN_8,
    CGSS_GAIN_50, CGSS_GAIN_100, CGSS_GAIN_200, CGSS_GAIN_400
  } cgss_gain_t;

  typedef struct packed {
    logic              spare;
    cgss_gain_t        gain;
    logic [HALF_W-1:0] assembly;
    logic [HALF_W-1:0] channel;
  } cgss_entry_t;

  typedef struct packed {
    logic [IDX_W-1:0]  entry;
    logic [DATA_W-1:0] sample;
  } cgss_result_t;

  localparam int RES_W = $bits(cgss_result_t);

  typedef enum logic [1:0] {
    CGSS_IDLE, CGSS_LOAD, CGSS_WAIT, CGSS_CONV
  } cgss_state_t;

endpackage

// ---- rtl/cgss_fifo.sv ----
// result buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cgss_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_q, wr_d, rd_q, rd_d;
  logic         push, pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_q[PW] != rd_q[PW]) &&
                       (wr_q[PW-1:0] == rd_q[PW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end
endmodule // cgss_fifo
`default_nettype wire

// ---- verification/cgss_checker.sv ----
// port checker for the channel-gain scan sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cgss_checker
  import cgss_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [IDX_W-1:0]  queue_last,
  input wire logic              acq_enable,
  input wire logic [ADDR_W-1:0] mux_addr,
  input wire logic [GAIN_W-1:0] gain_sel,
  input wire logic              conv_start,
  input wire logic              conv_done,
  input wire logic              res_valid,
  input wire logic              res_ready,
  input wire cgss_result_t      res_data,
  input wire logic              busy,
  input wire logic [IDX_W-1:0]  cur_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // conversion steps
  // ****
  sequence s_done;
    busy && conv_done && acq_enable;
  endsequence
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  start_busy_a: assert property (conv_start |-> busy)
    else $error("start without busy");
  one_flight_a: assert property (conv_start |-> !$past(busy))
    else $error("start while a conversion runs");
  addr_hold_a: assert property (busy |->
      $stable(mux_addr) && $stable(gain_sel))
    else $error("address or gain moved in a conversion");
  done_clear_a: assert property (s_done |=> !busy)
    else $error("busy kept after done");
  result_push_a: assert property (s_done |-> ##2 res_valid)
    else $error("no result after done");
  index_step_a: assert property (s_done |-> ##2 (cur_index ==
      (($past(cur_index, 2) == queue_last) ? 8'h00 :
       $past(cur_index, 2) + 8'h01)))
    else $error("queue index did not step or wrap");
  out_hold_a: assert property (res_valid && !res_ready |=>
      res_valid && $stable(res_data))
    else $error("result dropped while stalled");
  idle_quiet_a: assert property (!acq_enable [*3] |-> !conv_start && !busy)
    else $error("conversion while disabled");
endmodule // cgss_checker
bind cgss_sequencer cgss_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .queue_last(queue_last),
  .acq_enable(acq_enable), .mux_addr(mux_addr), .gain_sel(gain_sel),
  .conv_start(conv_start), .conv_done(conv_done), .res_valid(res_valid),
  .res_ready(res_ready), .res_data(res_data), .busy(busy),
  .cur_index(cur_index)
);
`default_nettype wire

// ---- verification/cgss_conv_model.sv ----
// converter and remote assembly stand-in, answers in 1..12 cycles
// assumes conv_start pulses on clk
`timescale 1ns/1ps
`default_nettype none
module cgss_conv_model
  import cgss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] mux_addr,
  input  wire logic [GAIN_W-1:0] gain_sel,
  input  wire logic              conv_start,
  output logic                   conv_done,
  output logic [DATA_W-1:0]      adc_raw
);
  int unsigned left = 0;
  initial begin
    conv_done = 1'b0;
    adc_raw = 16'h0000;
  end
  always @(posedge clk) begin
    conv_done <= 1'b0;
    // released data lines never keep the last sample
    adc_raw <= ~adc_raw;
    if (conv_start) begin
      left <= 1 + $urandom % 12;
    end else if (left == 1) begin
      conv_done <= 1'b1;
      adc_raw <= {gain_sel, 1'b1, mux_addr[11:6], mux_addr[5:0]};
      left <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule // cgss_conv_model
`default_nettype wire

// ---- verification/cgss_sequencer_bench.sv ----
// self-checking bench of the channel-gain scan sequencer
// assumes the converter model beside the design and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cgss_sequencer_bench
  import cgss_pkg::*;
;
  logic clk, sys_rst, q_wr_en, acq_enable, burst_mode, bipolar, hold_rdy;
  logic ext_pacer_sel, ext_pacer_rise, ext_pacer_pin, res_ready;
  logic conv_start, conv_done, res_valid, busy;
  logic [IDX_W-1:0] q_wr_index, queue_last, cur_index, exp_idx;
  logic [DIV_W-1:0] pacer_div1, pacer_div2;
  logic [6:0]       burst_period_us;
  logic [ADDR_W-1:0] mux_addr;
  logic [GAIN_W-1:0] gain_sel;
  logic [DATA_W-1:0] adc_raw;
  cgss_entry_t      q_wr_data, qmem [Q_DEPTH];
  cgss_result_t     res_data, expq [$];
  int errors = 0, n_compared = 0, cyc = 0, last_st = -1, exp_gap = 0;
  int n_starts = 0;
  cgss_sequencer dut (
    .clk(clk), .sys_rst(sys_rst), .q_wr_en(q_wr_en), .q_wr_index(q_wr_index),
    .q_wr_data(q_wr_data), .queue_last(queue_last), .acq_enable(acq_enable),
    .burst_mode(burst_mode), .bipolar(bipolar), .ext_pacer_sel(ext_pacer_sel),
    .ext_pacer_rise(ext_pacer_rise), .pacer_div1(pacer_div1),
    .pacer_div2(pacer_div2), .burst_period_us(burst_period_us),
    .ext_pacer_pin(ext_pacer_pin), .mux_addr(mux_addr), .gain_sel(gain_sel),
    .conv_start(conv_start), .conv_done(conv_done), .adc_raw(adc_raw),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .busy(busy), .cur_index(cur_index));
  cgss_conv_model u_conv (
    .clk(clk), .mux_addr(mux_addr), .gain_sel(gain_sel),
    .conv_start(conv_start), .conv_done(conv_done), .adc_raw(adc_raw));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) res_ready <= #1 !hold_rdy && $urandom_range(1);
  task automatic fail(input string m);
    errors++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic final_report;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****
  // result and spacing monitor
  // ****
  always @(posedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      n_compared++;
      if (expq.size() == 0) fail("unexpected result");
      else if (res_data !== expq.pop_front()) fail("result wrong");
    end
    if (conv_start === 1'b1) begin
      n_starts++;
      if (exp_gap != 0 && last_st >= 0 &&
          !(burst_mode && cur_index == 0)) begin
        n_compared++;
        if (cyc - last_st != exp_gap)
          fail("start spacing");
      end
      last_st = cyc;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic expect_n(input int n);
    cgss_entry_t e;
    repeat (n) begin
      e = qmem[exp_idx];
      expq.push_back({exp_idx, {e.gain, 1'b1, e.assembly, e.channel}
                      ^ (bipolar ? SIGN_FLIP : 16'h0000)});
      exp_idx = (exp_idx == queue_last) ? 8'h00 : exp_idx + 8'h01;
    end
  endtask
  task automatic drain(input int lim);
    while (expq.size() != 0 && lim > 0) begin
      tick(1);
      lim--;
    end
    if (expq.size() != 0) begin
      fail("timeout");
      final_report();
    end
  endtask
  task automatic cfg(input logic b, p, input int d1, d2, us, last);
    burst_mode = b;
    bipolar = p;
    pacer_div1 = d1[15:0];
    pacer_div2 = d2[15:0];
    burst_period_us = us[6:0];
    queue_last = last[7:0];
  endtask
  task automatic run(input int n, gap, lim, input logic stall);
    exp_gap = gap;
    hold_rdy = stall;
    n_starts = 0;
    expect_n(n);
    acq_enable = 1'b1;
    if (stall) begin
      tick(17000);
      n_compared++;
      if (n_starts != FIFO_DEPTH) fail("full buffer did not stall");
      hold_rdy = 1'b0;
    end
    drain(lim);
    acq_enable = 1'b0;
    exp_idx = 8'h00;
    last_st = -1;
    tick(4);
  endtask
  initial begin
    cgss_entry_t e;
    int k;
    void'($urandom(83281));
    {sys_rst, q_wr_en, acq_enable, hold_rdy, ext_pacer_sel} = 5'h10;
    {ext_pacer_rise, ext_pacer_pin, q_wr_index, q_wr_data} = '0;
    exp_idx = 8'h00;
    cfg(1'b0, 1'b0, 20, 1, 64, 8);
    tick(8);
    sys_rst = 1'b0;
    n_compared++;
    if (mux_addr !== 12'h000 || busy !== 1'b0 || res_valid !== 1'b0 ||
        gain_sel !== 3'h0 || cur_index !== 8'h00 || conv_start !== 1'b0)
      fail("reset");
    for (int i = 0; i < 9; i++) begin
      e = 16'($urandom);
      e.gain = cgss_gain_t'(i[2:0]);
      if (i == 8) e = qmem[7];
      qmem[i] = e;
      q_wr_en = 1'b1;
      q_wr_index = i[7:0];
      q_wr_data = e;
      tick(1);
    end
    q_wr_en = 1'b0;
    run(11, 500, 7000, 1'b0);
    cfg(1'b0, 1'b1, 60, 2, 10, 8);
    run(9, 1200, 12000, 1'b0);
    cfg(1'b1, 1'b0, 500, 0, 3, 8);
    run(9, 500, 11000, 1'b0);
    cfg(1'b1, 1'b0, 1000, 1, 100, 2);
    run(6, 3200, 31000, 1'b0);
    cfg(1'b0, 1'b0, 50, 1, 10, 2);
    run(40, 0, 6000, 1'b1);
    ext_pacer_sel = 1'b1;
    for (int r = 0; r < 2; r++) begin
      ext_pacer_rise = r[0];
      ext_pacer_pin = !r[0];
      tick(10);
      acq_enable = 1'b1;
      repeat (4) begin
        n_starts = 0;
        if (ext_pacer_pin != r[0]) expect_n(1);
        ext_pacer_pin = !ext_pacer_pin;
        for (k = 0; k < 30 && n_starts == 0; k++) tick(1);
        n_compared++;
        if (n_starts != int'(ext_pacer_pin == r[0])) fail("pacer edge");
        tick(600);
      end
      drain(100);
      acq_enable = 1'b0;
      exp_idx = 8'h00;
      tick(4);
    end
    final_report();
  end
endmodule // cgss_sequencer_bench
`default_nettype wire
